// ### hw/pcg_top.sv
// Port clock gate controller: run, sleep and deep-sleep enables for ports A to H.
// Assumes a single-cycle register master on REF_CLK, and that port accesses are
// presented on the access port with the port number already decoded.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "pcg_cfg.svh"
module pcg_top
  import pcg_pkg::*;
#(
  parameter int NPORTS = `PCG_NPORTS
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic SLEEP_REQ,
  input wire logic DEEP_SLEEP_REQ,
  input wire logic PORT_ACC_VALID,
  input wire logic PORT_ACC_WRITE,
  input wire logic [2:0] PORT_ACC_SEL,
  output logic PORT_ACC_FAULT,
  output logic [NPORTS-1:0] PORT_CLK,
  output logic [NPORTS-1:0] PORT_ENABLE,
  output logic [2:0] POWER_MODE,
  output logic IRQ
);
  pcg_bus_t bus;
  pcg_access_t acc;
  logic [NPORTS-1:0] run_port_clock_gate_q, run_port_clock_gate_d;
  logic [NPORTS-1:0] sleep_port_clock_gate_q, sleep_port_clock_gate_d;
  logic [NPORTS-1:0] deep_sleep_port_clock_gate_q, deep_sleep_port_clock_gate_d;
  logic [31:0] run_clock_config_q, run_clock_config_d;
  logic [1:0] int_status_q, int_status_d;
  logic [1:0] int_mask_q, int_mask_d;
  logic [3:0] fault_info_q, fault_info_d;
  logic [31:0] rdata_q, rdata_d;
  logic fault_q, fault_d;
  pcg_mode_t mode_q, mode_d;
  logic [NPORTS-1:0] active_gate;
  logic [NPORTS-1:0] gate_q, gate_d;
  logic [NPORTS-1:0] en_latched;
  logic auto_clock_gating_enable;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign acc = '{port: PORT_ACC_SEL, valid: PORT_ACC_VALID, write: PORT_ACC_WRITE};
  assign auto_clock_gating_enable = run_clock_config_q[`PCG_ACG_BIT];

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // Mode tracking: deep sleep has priority over plain sleep.
  always_comb begin
    case (mode_q)
      PCG_RUN, PCG_SLEEP, PCG_DEEP: begin
        if (DEEP_SLEEP_REQ) begin
          mode_d = PCG_DEEP;
        end else if (SLEEP_REQ) begin
          mode_d = PCG_SLEEP;
        end else begin
          mode_d = PCG_RUN;
        end
      end
      default: begin
        mode_d = PCG_RUN;
      end
    endcase
  end

  // Gating selection; without auto gating the run set holds in every mode.
  always_comb begin
    active_gate = run_port_clock_gate_q;
    if (auto_clock_gating_enable) begin
      case (mode_q)
        PCG_SLEEP: begin
          active_gate = sleep_port_clock_gate_q;
        end
        PCG_DEEP: begin
          active_gate = deep_sleep_port_clock_gate_q;
        end
        default: begin
          active_gate = run_port_clock_gate_q;
        end
      endcase
    end
    gate_d = active_gate;
  end

  // Register writes; only bits 7 to 0 of each gating register are stored.
  always_comb begin
    run_port_clock_gate_d = run_port_clock_gate_q;
    sleep_port_clock_gate_d = sleep_port_clock_gate_q;
    deep_sleep_port_clock_gate_d = deep_sleep_port_clock_gate_q;
    run_clock_config_d = run_clock_config_q;
    int_mask_d = int_mask_q;
    if (bus.wr) begin
      if (hit(bus.addr, `PCG_RUN_GATE_OFF)) begin
        run_port_clock_gate_d = bus.wdata[NPORTS-1:0];
      end
      if (hit(bus.addr, `PCG_SLEEP_GATE_OFF)) begin
        sleep_port_clock_gate_d = bus.wdata[NPORTS-1:0];
      end
      if (hit(bus.addr, `PCG_DEEP_GATE_OFF)) begin
        deep_sleep_port_clock_gate_d = bus.wdata[NPORTS-1:0];
      end
      if (hit(bus.addr, `PCG_RUN_CFG_OFF)) begin
        run_clock_config_d = bus.wdata;
      end
      if (hit(bus.addr, `PCG_INT_MASK_OFF)) begin
        int_mask_d = bus.wdata[1:0];
      end
    end
  end

  // Read data; reserved and unmapped bits read as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `PCG_RUN_GATE_OFF: rdata_d = {{(32-NPORTS){1'b0}}, run_port_clock_gate_q};
        `PCG_SLEEP_GATE_OFF: rdata_d = {{(32-NPORTS){1'b0}}, sleep_port_clock_gate_q};
        `PCG_DEEP_GATE_OFF: rdata_d = {{(32-NPORTS){1'b0}}, deep_sleep_port_clock_gate_q};
        `PCG_RUN_CFG_OFF: rdata_d = run_clock_config_q;
        `PCG_INT_STATUS_OFF: rdata_d = {30'h0000_0000, int_status_q};
        `PCG_INT_MASK_OFF: rdata_d = {30'h0000_0000, int_mask_q};
        `PCG_FAULT_ADDR_OFF: rdata_d = {28'h000_0000, fault_info_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Port access checking against the clocks that are actually running now.
  always_comb begin
    fault_d = acc.valid & ~en_latched[acc.port];
    fault_info_d = fault_info_q;
    if (fault_d) begin
      fault_info_d = {acc.write, acc.port};
    end
  end

  // Sticky events; a new event in the clearing read's cycle survives the clear.
  always_comb begin
    logic [1:0] ev;
    ev = 2'b00;
    ev[`PCG_EV_FAULT] = fault_d;
    ev[`PCG_EV_CHANGE] = (gate_d != gate_q);
    int_status_d = int_status_q;
    if (bus.rd && hit(bus.addr, `PCG_INT_STATUS_OFF)) begin
      int_status_d = 2'b00;
    end
    int_status_d = int_status_d | ev;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      run_port_clock_gate_q <= `PCG_GATE_RESET;
      sleep_port_clock_gate_q <= `PCG_GATE_RESET;
      deep_sleep_port_clock_gate_q <= `PCG_GATE_RESET;
      run_clock_config_q <= `PCG_CFG_RESET;
      int_status_q <= 2'b00;
      int_mask_q <= 2'b00;
      fault_info_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
      fault_q <= 1'b0;
      mode_q <= PCG_RUN;
      gate_q <= `PCG_GATE_RESET;
    end else begin
      run_port_clock_gate_q <= run_port_clock_gate_d;
      sleep_port_clock_gate_q <= sleep_port_clock_gate_d;
      deep_sleep_port_clock_gate_q <= deep_sleep_port_clock_gate_d;
      run_clock_config_q <= run_clock_config_d;
      int_status_q <= int_status_d;
      int_mask_q <= int_mask_d;
      fault_info_q <= fault_info_d;
      rdata_q <= rdata_d;
      fault_q <= fault_d;
      mode_q <= mode_d;
      gate_q <= gate_d;
    end
  end

  // One gate cell per port; the registered selection feeds it so it moves on an edge.
  for (genvar i = 0; i < NPORTS; i++) begin : g_gate
    pcg_clock_gate u_gate (
      .clk(REF_CLK),
      .rst(RESET),
      .en(gate_q[i]),
      .gclk(PORT_CLK[i]),
      .en_q(en_latched[i])
    );
  end

  assign PORT_ENABLE = gate_q;
  assign PORT_ACC_FAULT = fault_q;
  assign POWER_MODE = mode_q;
  assign RDATA = rdata_q;
  assign IRQ = |(int_status_q & int_mask_q);
endmodule : pcg_top

// ### hw/pcg_cfg.svh
// Offsets, field positions, reset values and sizes of the port clock gate block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH
`define PCG_SYSCTL_BASE 32'h400F_E000
`define PCG_RUN_GATE_OFF 12'h108
`define PCG_SLEEP_GATE_OFF 12'h118
`define PCG_DEEP_GATE_OFF 12'h128
`define PCG_RUN_CFG_OFF 12'h060
`define PCG_INT_STATUS_OFF 12'h200
`define PCG_INT_MASK_OFF 12'h204
`define PCG_FAULT_ADDR_OFF 12'h208
`define PCG_ACG_BIT 27
`define PCG_PORT_MSB 7
`define PCG_GATE_RESET 8'h00
`define PCG_CFG_RESET 32'h0000_0000
`define PCG_PORT_SPAN 32'h0000_1000
`define PCG_NPORTS 8
`define PCG_EV_FAULT 0
`define PCG_EV_CHANGE 1
`endif

// ### hw/pcg_pkg.sv
// Types shared by the port clock gate block.
// Assumes the constants header is on the include path.
`include "pcg_cfg.svh"
package pcg_pkg;
  typedef enum logic [2:0] {
    PCG_RUN = 3'b001,
    PCG_SLEEP = 3'b010,
    PCG_DEEP = 3'b100
  } pcg_mode_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pcg_bus_t;
  typedef struct packed {
    logic [2:0] port;
    logic valid;
    logic write;
  } pcg_access_t;
endpackage : pcg_pkg

// ### hw/pcg_clock_gate.sv
// One glitch-free port clock gate built as a latch-free enable register.
// Assumes the enable changes only on the system clock; the gated clock is REF_CLK and the falling-edge copy of enable.
`timescale 1ns/1ps
module pcg_clock_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  output logic gclk,
  output logic en_q
);
  logic en_d;
  always_comb begin
    en_d = en;
  end
  // The enable is taken on the falling edge so it never moves while the clock is high.
  always_ff @(negedge clk) begin
    if (rst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end
  assign gclk = clk & en_q;
endmodule : pcg_clock_gate

// ### sim/pcg_top_sva.sv
// Port-level checker for the port clock gate controller.
// Assumes REF_CLK is the only clock and RESET is synchronous, active high.
`timescale 1ns/1ps
module pcg_top_sva
  import pcg_pkg::*;
#(
  parameter int NPORTS = 8
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [11:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic SLEEP_REQ,
  input wire logic DEEP_SLEEP_REQ,
  input wire logic PORT_ACC_VALID,
  input wire logic [2:0] PORT_ACC_SEL,
  input wire logic PORT_ACC_FAULT,
  input wire logic [NPORTS-1:0] PORT_CLK,
  input wire logic [NPORTS-1:0] PORT_ENABLE,
  input wire logic [2:0] POWER_MODE
);
  logic sel_en;
  assign sel_en = PORT_ENABLE[PORT_ACC_SEL];
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  sequence s_run_wr(logic [11:0] a);
    WR && ADDR == a && POWER_MODE == PCG_RUN && !SLEEP_REQ && !DEEP_SLEEP_REQ;
  endsequence
  sequence s_quiet;
    !WR && !SLEEP_REQ && !DEEP_SLEEP_REQ;
  endsequence
  AST_RUN_WR: assert property (s_run_wr(12'h108) ##1 s_quiet |=>
    PORT_ENABLE == NPORTS'($past(WDATA, 2))) else $error("run gate write not applied");
  AST_IDLE_WR: assert property ((s_run_wr(12'h118) or s_run_wr(12'h128))
    ##1 s_quiet |=> $stable(PORT_ENABLE)) else $error("idle gate write changed run enables");
  AST_MODE: assert property (!$past(RESET) |-> POWER_MODE ==
    ($past(DEEP_SLEEP_REQ) ? PCG_DEEP : $past(SLEEP_REQ) ? PCG_SLEEP : PCG_RUN))
    else $error("power mode wrong");
  AST_FAULT: assert property (PORT_ACC_VALID |=> PORT_ACC_FAULT != $past(sel_en))
    else $error("fault does not match port enable");
  AST_NO_FAULT: assert property (!PORT_ACC_VALID |=> !PORT_ACC_FAULT)
    else $error("fault without access");
  AST_RSV: assert property (RD && ADDR[11:8] == 4'h1 && ADDR[3:0] == 4'h8
    && ADDR[7:4] inside {4'h0, 4'h1, 4'h2} |=> RDATA[31:8] == 24'h00_0000)
    else $error("reserved gate bits not zero");
  AST_RST: assert property ($fell(RESET) |-> PORT_ENABLE == '0 && POWER_MODE == PCG_RUN)
    else $error("reset state wrong");
  AST_CLK: assert property (@(negedge REF_CLK) disable iff (RESET)
    PORT_CLK == $past(PORT_ENABLE)) else $error("port clock not following enable");
endmodule : pcg_top_sva
bind pcg_top pcg_top_sva #(.NPORTS(NPORTS)) pcg_top_sva_inst (.REF_CLK(REF_CLK),
  .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SLEEP_REQ(SLEEP_REQ), .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ), .PORT_ACC_VALID(PORT_ACC_VALID),
  .PORT_ACC_SEL(PORT_ACC_SEL), .PORT_ACC_FAULT(PORT_ACC_FAULT), .PORT_CLK(PORT_CLK),
  .PORT_ENABLE(PORT_ENABLE), .POWER_MODE(POWER_MODE));

// ### sim/pcg_top_tb.sv
// Self-checking bench for the port clock gate controller.
// Assumes pcg_top and its bound checker are compiled before this file.
`timescale 1ns/1ps
module pcg_top_tb
  import pcg_pkg::*;
;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [11:0] ADDR = 12'h000;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0, RD = 1'b0, SLEEP_REQ = 1'b0, DEEP_SLEEP_REQ = 1'b0;
  logic PORT_ACC_VALID = 1'b0, PORT_ACC_WRITE = 1'b0, PORT_ACC_FAULT, IRQ, f;
  logic [2:0] PORT_ACC_SEL = 3'h0, POWER_MODE;
  logic [31:0] RDATA, v;
  logic [7:0] PORT_CLK, PORT_ENABLE;
  int errors = 0, total_checks = 0, cyc = 0;
  pcg_top #(.NPORTS(8)) pcg_top_inst (.REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP_REQ(SLEEP_REQ),
    .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ), .PORT_ACC_VALID(PORT_ACC_VALID),
    .PORT_ACC_WRITE(PORT_ACC_WRITE), .PORT_ACC_SEL(PORT_ACC_SEL),
    .PORT_ACC_FAULT(PORT_ACC_FAULT), .PORT_CLK(PORT_CLK), .PORT_ENABLE(PORT_ENABLE),
    .POWER_MODE(POWER_MODE), .IRQ(IRQ));
  initial begin
    forever #5 REF_CLK = ~REF_CLK;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  task acc(input logic [2:0] s, output logic flt);
    @(posedge REF_CLK);
    PORT_ACC_VALID <= 1'b1;
    PORT_ACC_SEL <= s;
    PORT_ACC_WRITE <= s[0];
    @(posedge REF_CLK);
    PORT_ACC_VALID <= 1'b0;
    #1 flt = PORT_ACC_FAULT;
  endtask : acc
  // The mode path has two register stages; four cycles leave margin.
  task mode(input logic s, input logic d, input logic [7:0] e);
    @(posedge REF_CLK);
    SLEEP_REQ <= s;
    DEEP_SLEEP_REQ <= d;
    repeat (4) @(posedge REF_CLK);
    #1 chk("enable", 32'(e), 32'(PORT_ENABLE));
    chk("mode", 32'(d ? PCG_DEEP : s ? PCG_SLEEP : PCG_RUN), 32'(POWER_MODE));
  endtask : mode
  task test_reset();
    for (int i = 0; i < 3; i++) begin
      rd(12'h108 + 12'(i * 16), v);
      chk("gate reset", 32'h0, v);
    end
    chk("enable reset", 32'h0, 32'(PORT_ENABLE));
    $display("test_reset done");
  endtask : test_reset
  task test_ports();
    for (int i = 0; i < 8; i++) begin
      wr(12'h108, 32'h0000_0001 << i);
      acc(3'(i), f);
      chk("enable", 32'h0000_0001 << i, 32'(PORT_ENABLE));
      chk("fault on", 32'h0, 32'(f));
      acc(3'(i + 1), f);
      chk("fault off", 32'h1, 32'(f));
    end
    $display("test_ports done");
  endtask : test_ports
  task test_rsv();
    wr(12'h118, 32'hFFFF_FFFF);
    rd(12'h118, v);
    chk("sleep gate", 32'h0000_00FF, v);
    wr(12'h300, 32'hFFFF_FFFF);
    rd(12'h300, v);
    chk("unmapped", 32'h0, v);
    $display("test_rsv done");
  endtask : test_rsv
  task test_modes();
    wr(12'h108, 32'h0000_003C);
    wr(12'h118, 32'h0000_00F0);
    wr(12'h128, 32'h0000_000F);
    mode(1'b1, 1'b0, 8'h3C);
    wr(12'h060, 32'h0800_0000);
    mode(1'b1, 1'b0, 8'hF0);
    mode(1'b0, 1'b1, 8'h0F);
    mode(1'b1, 1'b1, 8'h0F);
    mode(1'b0, 1'b0, 8'h3C);
    $display("test_modes done");
  endtask : test_modes
  task test_irq();
    rd(12'h200, v);
    chk("change event", 32'h2, v & 32'h0000_0002);
    wr(12'h204, 32'h0000_0001);
    acc(3'h0, f);
    chk("fault A", 32'h1, 32'(f));
    for (int i = 0; i < 8 && IRQ !== 1'b1; i++) @(posedge REF_CLK);
    #1 chk("irq set", 32'h1, 32'(IRQ));
    rd(12'h200, v);
    chk("status", 32'h1, v & 32'h0000_0001);
    repeat (2) @(posedge REF_CLK);
    #1 chk("irq clear", 32'h0, 32'(IRQ));
    wr(12'h204, 32'h0);
    acc(3'h1, f);
    repeat (4) @(posedge REF_CLK);
    #1 chk("irq masked", 32'h0, 32'(IRQ));
    rd(12'h208, v);
    chk("fault info", 32'h9, v);
    $display("test_irq done");
  endtask : test_irq
  task conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge REF_CLK);
    RESET <= 1'b0;
    test_reset();
    test_ports();
    test_rsv();
    test_modes();
    test_irq();
    conclude();
  end
endmodule : pcg_top_tb
